/* File: pwm_update_irq_pkg.sv */
// constants for the pwm active-copy control and interrupt register block
// assumes a single 50 MHz system clock and a plain strobe register port
package pwm_update_irq_pkg;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [11:0] OFF_CAPTURE_STATUS = 12'h108;
    localparam logic [11:0] OFF_UPDATE_CFG     = 12'h10c;
    localparam logic [11:0] OFF_IRQ_ENABLE     = 12'h110;
    localparam logic [11:0] OFF_IRQ_RAW        = 12'h114;
    localparam logic [11:0] OFF_IRQ_MASKED     = 12'h118;
    localparam logic [11:0] OFF_IRQ_CLEAR      = 12'h11c;

    // ==========================================================
    // active_update_config field positions
    localparam int CFG_GLOBAL_EN    = 0;
    localparam int CFG_GLOBAL_FORCE = 1;
    localparam int CFG_OP_BASE      = 2;
    localparam int CFG_OP_STRIDE    = 2;
    localparam int CFG_OP_EN_OFS    = 0;
    localparam int CFG_OP_FORCE_OFS = 1;
    localparam int CFG_WIDTH        = 8;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // ==========================================================
    // interrupt source positions, each a group of three
    localparam int IRQ_TIMER_STOP  = 0;
    localparam int IRQ_TIMER_ZERO  = 3;
    localparam int IRQ_TIMER_PER   = 6;
    localparam int IRQ_FAULT_START = 9;
    localparam int IRQ_FAULT_END   = 12;
    localparam int IRQ_CMP_A       = 15;
    localparam int IRQ_CMP_B       = 18;
    localparam int IRQ_CBC         = 21;
    localparam int IRQ_ONE_SHOT    = 24;
    localparam int IRQ_CAPTURE     = 27;
    localparam int IRQ_SOURCES     = 30;
    localparam logic [29:0] IRQ_RESET = 30'h0000_0000;

endpackage : pwm_update_irq_pkg

/* File: pwm_update_and_irq_regs.sv */
// active-copy control and 30-source interrupt registers of a three-operator pwm unit
// assumes event inputs are one-cycle pulses from logic on clk_sys_i
//
// Contract
// - toggling an operator's forced-copy bit gives that operator a forced shadow-to-active copy.
// - an operator may take scheduled copies only while its own enable and the global enable are both set.
// - toggling the global forced-copy bit forces a copy of every active register in the unit.
// - the global enable is master permission; when clear no operator enable has effect.
// - a 32-bit read-write enable register holds one enable bit per source, 30 in all, gating the masked status.
// - each event is recorded in a read-only raw status bit; writes to that register do nothing.
// - a read-only masked status register shows raw status and enable bit by bit.
// - each of three capture channels raises its own source on a capture.
// - each fault-handler output raises separate sources for one-shot and cycle-by-cycle actions.
// - each fault input raises one source when its fault begins and another when it ends.
// - each operator raises separate sources for its compare-a and compare-b events.
// - each timer raises separate sources on reaching its period and on reaching zero.
// - each timer raises a source when it stops counting.
// - writing one to a bit of the write-only clear register clears that pending source; zero leaves it.
//
// The address-and-strobe port was chosen for this implementation.
module pwm_update_and_irq_regs
    import pwm_update_irq_pkg::*;
#(
    parameter int NUM_UNITS = 3,
    parameter int ADDR_W    = 12
) (
    input  wire logic              clk_sys_i,                     // system clock
    input  wire logic              rst_n_i,                       // async reset, low
    input  wire logic [ADDR_W-1:0] addr_i,                        // register byte address
    input  wire logic [31:0]       wdata_i,                       // write data
    input  wire logic              wr_i,                          // write strobe
    input  wire logic              rd_i,                          // read strobe
    output logic      [31:0]       rdata_o,                       // read data, cycle after rd_i
    input  wire logic [31:0]       capture_status_i,              // capture status word
    input  wire logic [2:0]        timer_stop_event_i,            // timer stopped pulses
    input  wire logic [2:0]        timer_zero_reached_event_i,    // timer zero pulses
    input  wire logic [2:0]        timer_period_reached_event_i,  // timer period pulses
    input  wire logic [2:0]        fault_start_event_i,           // fault begins pulses
    input  wire logic [2:0]        fault_end_event_i,             // fault ends pulses
    input  wire logic [2:0]        operator_compare_a_event_i,    // compare-a pulses
    input  wire logic [2:0]        operator_compare_b_event_i,    // compare-b pulses
    input  wire logic [2:0]        cycle_by_cycle_fault_action_i, // cbc action pulses
    input  wire logic [2:0]        one_shot_fault_action_i,       // one-shot action pulses
    input  wire logic [2:0]        capture_event_i,               // capture pulses
    output logic      [2:0]        operator_copy_allow_o,         // scheduled copy permitted
    output logic      [2:0]        operator_forced_copy_o,        // forced copy pulse per operator
    output logic                   global_forced_copy_o,          // forced copy pulse, whole unit
    output logic                   irq_o                          // interrupt request, level
);

    // ==========================================================
    // elaboration checks
    if (NUM_UNITS != 3) begin : g_bad_units
        $error("register layout serves exactly three units");
    end
    if (ADDR_W < 9) begin : g_bad_addr
        $error("address too narrow for the register map");
    end

    // ==========================================================
    // helpers
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
        hit = (a == ADDR_W'(off));
    endfunction : hit

    function automatic int op_bit(input int unit, input int ofs);
        op_bit = CFG_OP_BASE + unit * CFG_OP_STRIDE + ofs;
    endfunction : op_bit

    // ==========================================================
    // decode
    logic wr_cfg;
    logic wr_ena;
    logic wr_clr;
    assign wr_cfg = wr_i & hit(addr_i, OFF_UPDATE_CFG);
    assign wr_ena = wr_i & hit(addr_i, OFF_IRQ_ENABLE);
    assign wr_clr = wr_i & hit(addr_i, OFF_IRQ_CLEAR);

    // ==========================================================
    // active copy control
    logic [CFG_WIDTH-1:0] cfg_reg;
    logic [2:0]           allow_reg;
    logic [2:0]           op_force_reg;
    logic                 glob_force_reg;
    logic [CFG_WIDTH-1:0] cfg_next;

    always_comb begin
        cfg_next = wr_cfg ? wdata_i[CFG_WIDTH-1:0] : cfg_reg;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_reg <= CFG_RESET;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            allow_reg <= 3'h0;
        end else begin
            for (int u = 0; u < 3; u++) begin
                allow_reg[u] <= cfg_next[op_bit(u, CFG_OP_EN_OFS)] & cfg_next[CFG_GLOBAL_EN];
            end
        end
    end

    // pulse lands on the same edge the new toggle value is stored
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_force_reg   <= 3'h0;
            glob_force_reg <= 1'b0;
        end else begin
            glob_force_reg <= cfg_next[CFG_GLOBAL_FORCE] ^ cfg_reg[CFG_GLOBAL_FORCE];
            for (int u = 0; u < 3; u++) begin
                op_force_reg[u] <= (cfg_next[op_bit(u, CFG_OP_FORCE_OFS)]
                                    ^ cfg_reg[op_bit(u, CFG_OP_FORCE_OFS)])
                                   | (cfg_next[CFG_GLOBAL_FORCE] ^ cfg_reg[CFG_GLOBAL_FORCE]);
            end
        end
    end

    assign operator_copy_allow_o  = allow_reg;
    assign operator_forced_copy_o = op_force_reg;
    assign global_forced_copy_o   = glob_force_reg;

    // ==========================================================
    // interrupt sources
    logic [IRQ_SOURCES-1:0] ev;

    always_comb begin
        ev = '0;
        ev[IRQ_TIMER_STOP  +: 3] = timer_stop_event_i;
        ev[IRQ_TIMER_ZERO  +: 3] = timer_zero_reached_event_i;
        ev[IRQ_TIMER_PER   +: 3] = timer_period_reached_event_i;
        ev[IRQ_FAULT_START +: 3] = fault_start_event_i;
        ev[IRQ_FAULT_END   +: 3] = fault_end_event_i;
        ev[IRQ_CMP_A       +: 3] = operator_compare_a_event_i;
        ev[IRQ_CMP_B       +: 3] = operator_compare_b_event_i;
        ev[IRQ_CBC         +: 3] = cycle_by_cycle_fault_action_i;
        ev[IRQ_ONE_SHOT    +: 3] = one_shot_fault_action_i;
        ev[IRQ_CAPTURE     +: 3] = capture_event_i;
    end

    // ==========================================================
    // interrupt registers
    logic [IRQ_SOURCES-1:0] ena_reg;
    logic [IRQ_SOURCES-1:0] raw_reg;
    logic [IRQ_SOURCES-1:0] masked;
    logic                   irq_reg;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ena_reg <= IRQ_RESET;
        end else if (wr_ena) begin
            ena_reg <= wdata_i[IRQ_SOURCES-1:0];
        end
    end

    // a set in the same cycle as its clear wins; writes to raw are ignored
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            raw_reg <= IRQ_RESET;
        end else begin
            raw_reg <= (raw_reg & ~(wr_clr ? wdata_i[IRQ_SOURCES-1:0] : '0)) | ev;
        end
    end

    assign masked = raw_reg & ena_reg;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |masked;
        end
    end

    assign irq_o = irq_reg;

    // ==========================================================
    // read port
    logic [31:0] rdata_reg;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd_i) begin
            if (hit(addr_i, OFF_CAPTURE_STATUS)) begin
                rdata_reg <= capture_status_i;
            end else if (hit(addr_i, OFF_UPDATE_CFG)) begin
                rdata_reg <= {24'h00_0000, cfg_reg};
            end else if (hit(addr_i, OFF_IRQ_ENABLE)) begin
                rdata_reg <= {2'h0, ena_reg};
            end else if (hit(addr_i, OFF_IRQ_RAW)) begin
                rdata_reg <= {2'h0, raw_reg};
            end else if (hit(addr_i, OFF_IRQ_MASKED)) begin
                rdata_reg <= {2'h0, masked};
            end else begin
                rdata_reg <= 32'h0000_0000;
            end
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign rdata_o = rdata_reg;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_op0_toggle;
        wr_cfg && (wdata_i[op_bit(0, CFG_OP_FORCE_OFS)] != cfg_reg[op_bit(0, CFG_OP_FORCE_OFS)]);
    endsequence
    sequence s_glob_toggle;
        wr_cfg && (wdata_i[CFG_GLOBAL_FORCE] != cfg_reg[CFG_GLOBAL_FORCE]);
    endsequence

    a_op_forced_copy: assert property (s_op0_toggle |=> operator_forced_copy_o[0])
        else $error("operator toggle gave no forced copy");

    a_force_one_cycle: assert property (
        (operator_forced_copy_o[0] && !$past(wr_cfg)) |-> 0)
        else $error("forced copy pulse without a toggle write");

    a_global_forced: assert property (
        s_glob_toggle |=> global_forced_copy_o && (operator_forced_copy_o == 3'h7))
        else $error("global toggle did not force every copy");

    a_allow_gated: assert property (
        operator_copy_allow_o[1] |-> (cfg_reg[CFG_GLOBAL_EN] && cfg_reg[op_bit(1, CFG_OP_EN_OFS)]))
        else $error("copy allowed without both enables");

    a_enable_write: assert property (wr_ena |=> ena_reg == $past(wdata_i[29:0]))
        else $error("enable register did not take write");

    a_raw_records: assert property ((ev != '0) |=> ((raw_reg & $past(ev)) == $past(ev)))
        else $error("event not recorded in raw status");

    a_raw_write_ignored: assert property (
        (wr_i && hit(addr_i, OFF_IRQ_RAW) && ev == '0) |=> $stable(raw_reg))
        else $error("write to raw status changed it");

    a_clear_one: assert property (
        (wr_clr && wdata_i[IRQ_CAPTURE] && !ev[IRQ_CAPTURE]) |=> !raw_reg[IRQ_CAPTURE])
        else $error("clear write left source pending");

    a_masked_read: assert property (
        (rd_i && hit(addr_i, OFF_IRQ_MASKED)) |=> rdata_o == {2'h0, $past(raw_reg & ena_reg)})
        else $error("masked status read wrong");

    a_irq_level: assert property ((|masked) |=> irq_o ##0 1)
        else $error("interrupt not raised for masked source");

    a_irq_low: assert property ((masked == '0) |=> !irq_o)
        else $error("interrupt high with nothing pending");

    // ==========================================================
    // forced copies for the other operators and the quiet cases
    sequence s_op1_toggle;
        wr_cfg && (wdata_i[op_bit(1, CFG_OP_FORCE_OFS)] != cfg_reg[op_bit(1, CFG_OP_FORCE_OFS)]);
    endsequence
    sequence s_op2_toggle;
        wr_cfg && (wdata_i[op_bit(2, CFG_OP_FORCE_OFS)] != cfg_reg[op_bit(2, CFG_OP_FORCE_OFS)]);
    endsequence
    // a config write that keeps every toggle bit as stored
    sequence s_no_toggle;
        wr_cfg
        && (wdata_i[CFG_GLOBAL_FORCE] == cfg_reg[CFG_GLOBAL_FORCE])
        && (wdata_i[op_bit(0, CFG_OP_FORCE_OFS)] == cfg_reg[op_bit(0, CFG_OP_FORCE_OFS)])
        && (wdata_i[op_bit(1, CFG_OP_FORCE_OFS)] == cfg_reg[op_bit(1, CFG_OP_FORCE_OFS)])
        && (wdata_i[op_bit(2, CFG_OP_FORCE_OFS)] == cfg_reg[op_bit(2, CFG_OP_FORCE_OFS)]);
    endsequence
    sequence s_cfg_idle;
        !wr_cfg;
    endsequence

    a_op1_forced: assert property (s_op1_toggle |=> operator_forced_copy_o[1])
        else $error("operator 1 toggle gave no forced copy");

    a_op2_forced: assert property (s_op2_toggle |=> operator_forced_copy_o[2])
        else $error("operator 2 toggle gave no forced copy");

    // a pulse needs a change of a stored toggle bit, nothing else
    a_no_toggle_quiet: assert property (
        s_no_toggle |=> (operator_forced_copy_o == 3'h0) && !global_forced_copy_o)
        else $error("forced copy pulse without a toggle");

    a_idle_quiet: assert property (
        s_cfg_idle |=> (operator_forced_copy_o == 3'h0) && !global_forced_copy_o)
        else $error("forced copy pulse with no config write");

    a_global_pulse_op: assert property (
        global_forced_copy_o |-> (operator_forced_copy_o == 3'h7))
        else $error("global pulse missed an operator");

    // ==========================================================
    // copy permission
    a_global_master: assert property (
        !cfg_reg[CFG_GLOBAL_EN] |-> (operator_copy_allow_o == 3'h0))
        else $error("copy allowed with the global enable clear");

    a_allow_op0: assert property (
        (cfg_reg[CFG_GLOBAL_EN] && cfg_reg[op_bit(0, CFG_OP_EN_OFS)]) |-> operator_copy_allow_o[0])
        else $error("operator 0 copy refused with both enables set");

    a_allow_op1: assert property (
        (cfg_reg[CFG_GLOBAL_EN] && cfg_reg[op_bit(1, CFG_OP_EN_OFS)]) |-> operator_copy_allow_o[1])
        else $error("operator 1 copy refused with both enables set");

    a_allow_op2: assert property (
        operator_copy_allow_o[2] |-> (cfg_reg[CFG_GLOBAL_EN] && cfg_reg[op_bit(2, CFG_OP_EN_OFS)]))
        else $error("operator 2 copy allowed without both enables");

    // ==========================================================
    // the enable register holds without a write, and one source of each kind reaches its own raw bit
    a_enable_hold: assert property (!wr_ena |=> $stable(ena_reg))
        else $error("enable register changed without a write");

    a_capture_source: assert property (capture_event_i[1] |=> raw_reg[IRQ_CAPTURE+1])
        else $error("capture event not recorded");

    a_oneshot_source: assert property (one_shot_fault_action_i[2] |=> raw_reg[IRQ_ONE_SHOT+2])
        else $error("one-shot action not recorded");

    a_cbc_source: assert property (cycle_by_cycle_fault_action_i[0] |=> raw_reg[IRQ_CBC])
        else $error("cycle-by-cycle action not recorded");

    a_fault_start: assert property (fault_start_event_i[1] |=> raw_reg[IRQ_FAULT_START+1])
        else $error("fault start not recorded");

    a_fault_end: assert property (fault_end_event_i[2] |=> raw_reg[IRQ_FAULT_END+2])
        else $error("fault end not recorded");

    a_compare_a: assert property (operator_compare_a_event_i[0] |=> raw_reg[IRQ_CMP_A])
        else $error("compare-a event not recorded");

    a_compare_b: assert property (operator_compare_b_event_i[1] |=> raw_reg[IRQ_CMP_B+1])
        else $error("compare-b event not recorded");

    a_timer_period: assert property (timer_period_reached_event_i[2] |=> raw_reg[IRQ_TIMER_PER+2])
        else $error("timer period event not recorded");

    a_timer_zero: assert property (timer_zero_reached_event_i[0] |=> raw_reg[IRQ_TIMER_ZERO])
        else $error("timer zero event not recorded");

    a_timer_stop: assert property (timer_stop_event_i[1] |=> raw_reg[IRQ_TIMER_STOP+1])
        else $error("timer stop event not recorded");

    // ==========================================================
    // clearing, raw bit setting, the interrupt line and idle read data
    a_clear_zero: assert property (
        (wr_clr && raw_reg[IRQ_TIMER_STOP] && !wdata_i[IRQ_TIMER_STOP]) |=> raw_reg[IRQ_TIMER_STOP])
        else $error("clear with a zero bit dropped a pending source");

    // a raw bit only rises through its own event
    a_raw_no_self: assert property (
        (!ev[IRQ_CMP_B] && !raw_reg[IRQ_CMP_B]) |=> !raw_reg[IRQ_CMP_B])
        else $error("raw bit set without its event");

    a_irq_source: assert property (irq_o |-> $past(|masked))
        else $error("interrupt high without a masked source");

    a_read_idle: assert property (!rd_i |=> (rdata_o == 32'h0000_0000))
        else $error("read data not zero outside a read");

    // a source held off by its enable cannot reach the line
    a_masked_off: assert property (
        (ena_reg == '0) |=> !irq_o)
        else $error("interrupt high with every source disabled");

endmodule : pwm_update_and_irq_regs

/* File: test_pwm_update_and_irq_regs.sv */
// self-checking bench for the pwm active-copy control and interrupt registers
// assumes the design package is compiled first; the bench drives every port itself
`define CHK(a, e, m) begin n_tests++; if ((a) !== (e)) begin error_cnt++; $display("wrong value at %0t: %s", $time, m); end end
module test_pwm_update_and_irq_regs
    import pwm_update_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // stimulus and observed signals
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i   = 1'b0;
    logic [11:0] addr_i    = 12'h000;
    logic [31:0] wdata_i   = 32'h0;
    logic        wr_i      = 1'b0;
    logic        rd_i      = 1'b0;
    logic [31:0] cap_word  = 32'h1234_5678;
    logic [29:0] ev        = 30'h0;
    logic [31:0] rdata_o;
    logic [2:0]  operator_copy_allow_o;
    logic [2:0]  operator_forced_copy_o;
    logic        global_forced_copy_o;
    logic        irq_o;
    int          error_cnt = 0;
    int          n_tests   = 0;
    int          cyc       = 0;
    typedef struct { logic [7:0] cfg; logic [2:0] allow; } cfg_row_t;
    cfg_row_t rows [7] = '{'{8'h54, 3'h0}, '{8'h55, 3'h7}, '{8'h05, 3'h1}, '{8'h11, 3'h2},
                           '{8'h41, 3'h4}, '{8'h01, 3'h0}, '{8'h00, 3'h0}};

    pwm_update_and_irq_regs pwm_update_and_irq_regs_i (
        .clk_sys_i                     (clk_sys_i),
        .rst_n_i                       (rst_n_i),
        .addr_i                        (addr_i),
        .wdata_i                       (wdata_i),
        .wr_i                          (wr_i),
        .rd_i                          (rd_i),
        .rdata_o                       (rdata_o),
        .capture_status_i              (cap_word),
        .timer_stop_event_i            (ev[IRQ_TIMER_STOP+:3]),
        .timer_zero_reached_event_i    (ev[IRQ_TIMER_ZERO+:3]),
        .timer_period_reached_event_i  (ev[IRQ_TIMER_PER+:3]),
        .fault_start_event_i           (ev[IRQ_FAULT_START+:3]),
        .fault_end_event_i             (ev[IRQ_FAULT_END+:3]),
        .operator_compare_a_event_i    (ev[IRQ_CMP_A+:3]),
        .operator_compare_b_event_i    (ev[IRQ_CMP_B+:3]),
        .cycle_by_cycle_fault_action_i (ev[IRQ_CBC+:3]),
        .one_shot_fault_action_i       (ev[IRQ_ONE_SHOT+:3]),
        .capture_event_i               (ev[IRQ_CAPTURE+:3]),
        .operator_copy_allow_o         (operator_copy_allow_o),
        .operator_forced_copy_o        (operator_forced_copy_o),
        .global_forced_copy_o          (global_forced_copy_o),
        .irq_o                         (irq_o)
    );

    always #10 clk_sys_i = ~clk_sys_i;

    // ==========================================================
    // bus tasks and closing report
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        wr_i    <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string m);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        rd_i   <= 1'b0;
        @(negedge clk_sys_i);
        `CHK(rdata_o, e, m)
    endtask : rdc

    task automatic pulse(input logic [29:0] v);
        @(posedge clk_sys_i);
        ev <= v;
        @(posedge clk_sys_i);
        ev <= 30'h0;
    endtask : pulse

    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            test_done();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (3) @(posedge clk_sys_i);
        `CHK({irq_o, global_forced_copy_o, operator_forced_copy_o, operator_copy_allow_o}, 8'h00, "reset outputs")
        rst_n_i <= 1'b1;
        rdc(OFF_IRQ_ENABLE, 32'h0, "enable reset");
        rdc(OFF_IRQ_RAW, 32'h0, "raw reset");
        rdc(OFF_IRQ_MASKED, 32'h0, "masked reset");
        rdc(OFF_UPDATE_CFG, 32'h0, "cfg reset");
        rdc(OFF_CAPTURE_STATUS, 32'h1234_5678, "capture word");
        rdc(12'h200, 32'h0, "unmapped read");
        $display("test reset done");
        foreach (rows[k]) begin
            wr(OFF_UPDATE_CFG, {24'h0, rows[k].cfg});
            @(negedge clk_sys_i);
            `CHK(operator_copy_allow_o, rows[k].allow, "copy allow")
            `CHK(operator_forced_copy_o, 3'h0, "no toggle no pulse")
        end
        $display("test copy enable rows done");
        wr(OFF_IRQ_ENABLE, 32'hffff_ffff);
        rdc(OFF_IRQ_ENABLE, 32'h3fff_ffff, "enable width");
        for (int i = 0; i < IRQ_SOURCES; i++) begin
            pulse(30'h1 << i);
            rdc(OFF_IRQ_RAW, 32'h1 << i, "raw source");
            rdc(OFF_IRQ_MASKED, 32'h1 << i, "masked source");
            `CHK(irq_o, 1'b1, "irq raised")
            wr(OFF_IRQ_CLEAR, 32'h1 << i);
            rdc(OFF_IRQ_RAW, 32'h0, "source cleared");
            `CHK(irq_o, 1'b0, "irq dropped")
        end
        $display("test sources done");
        wr(OFF_IRQ_ENABLE, 32'h0);
        pulse(30'h20);
        wr(OFF_IRQ_RAW, 32'h0);
        rdc(OFF_IRQ_RAW, 32'h20, "raw ignores writes");
        rdc(OFF_IRQ_MASKED, 32'h0, "masked off");
        `CHK(irq_o, 1'b0, "irq masked")
        wr(OFF_IRQ_CLEAR, 32'hffff_ffdf);
        rdc(OFF_IRQ_RAW, 32'h20, "zero bits keep");
        wr(OFF_IRQ_ENABLE, 32'h20);
        rdc(OFF_IRQ_MASKED, 32'h20, "masked on");
        `CHK(irq_o, 1'b1, "irq unmasked")
        @(posedge clk_sys_i);
        ev      <= 30'h20;
        addr_i  <= OFF_IRQ_CLEAR;
        wdata_i <= 32'h20;
        wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        ev      <= 30'h0;
        wr_i    <= 1'b0;
        rdc(OFF_IRQ_RAW, 32'h20, "event beats clear");
        $display("test masking done");
        wr(OFF_UPDATE_CFG, 32'h08);
        @(negedge clk_sys_i);
        `CHK({global_forced_copy_o, operator_forced_copy_o}, 4'h1, "op0 pulse")
        @(negedge clk_sys_i);
        `CHK(operator_forced_copy_o, 3'h0, "pulse one cycle")
        @(posedge clk_sys_i);
        addr_i  <= OFF_UPDATE_CFG;
        wdata_i <= 32'h28;
        wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        wdata_i <= 32'ha8;
        @(negedge clk_sys_i);
        `CHK(operator_forced_copy_o, 3'h2, "op1 pulse")
        @(posedge clk_sys_i);
        wr_i    <= 1'b0;
        @(negedge clk_sys_i);
        `CHK(operator_forced_copy_o, 3'h4, "op2 back to back")
        wr(OFF_UPDATE_CFG, 32'haa);
        @(negedge clk_sys_i);
        `CHK({global_forced_copy_o, operator_forced_copy_o}, 4'hf, "global pulse")
        wr(OFF_UPDATE_CFG, 32'haa);
        @(negedge clk_sys_i);
        `CHK({global_forced_copy_o, operator_forced_copy_o}, 4'h0, "same value no pulse")
        $display("test forced copy done");
        test_done();
    end
endmodule : test_pwm_update_and_irq_regs
